// [hw/spwm_pkg.sv]
// Constants for the scalable pulse-width channel block
package spwm_pkg;
    // ------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_ENABLE = 6'h00;
    localparam logic [5:0] IDX_POLARITY = 6'h01;
    localparam logic [5:0] IDX_SCALED_CHOICE = 6'h02;
    localparam logic [5:0] IDX_PRESCALE = 6'h03;
    localparam logic [5:0] IDX_CENTRE = 6'h04;
    localparam logic [5:0] IDX_CTRL = 6'h05;
    localparam logic [5:0] IDX_BASE_PAIR = 6'h06;
    localparam logic [5:0] IDX_SCALE_ONE = 6'h08;
    localparam logic [5:0] IDX_SCALE_TWO = 6'h09;
    localparam logic [5:0] IDX_COUNT0 = 6'h0C;
    localparam logic [5:0] IDX_PERIOD0 = 6'h14;
    localparam logic [5:0] IDX_DUTY0 = 6'h1C;
    localparam logic [5:0] IDX_LAST = 6'h27;
    // ------------------------------------------------------------
    // Field layout and write masks
    // ------------------------------------------------------------
    localparam int FIRST_PRESCALE_LSB = 0;
    localparam int SECOND_PRESCALE_LSB = 4;
    localparam int JOIN_LSB = 4;
    localparam int WAIT_STOP_BIT = 3;
    localparam int FREEZE_STOP_BIT = 2;
    localparam logic [7:0] PRESCALE_WMASK = 8'h77;
    localparam logic [7:0] CTRL_WMASK = 8'hFC;
    localparam logic [7:0] REG_RESET = 8'h00;
    // ------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int MAX_CH = 8;
endpackage : spwm_pkg

// [hw/spwm_top.sv]
// Scalable pulse-width channels with an AXI4-Lite register slave
// Functional notes
// - Two, four, six or eight channels are built, added in pairs from channel zero.
// - Every channel has its own counter and its own period and duty values.
// - Written period and duty take effect when the counter reaches zero or the channel is off.
// - Each channel has an enable bit that starts or stops its waveform.
// - Each channel selects whether the duty portion is driven high or low.
// - Each channel runs left aligned or centre aligned.
// - Adjacent channels can be joined into one 16-bit channel.
// - Four clock sources exist and each channel may pick any of them.
// - In wait mode the prescaler stops only when the wait stop bit is one.
// - In freeze mode the prescaler stops only when the freeze stop bit is one.
// - Reserved bits read zero and ignore writes.
// - Registers sit at fixed offsets from a base chosen at integration.
// - Each present channel drives its own output pin.
// - An enabled waveform starts at the next cycle of the selected clock source.
// - In a joined pair the low-order byte enable rules and the other output stays off.
// - With all present channels off the prescaler counter stops.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/10ps
module spwm_top import spwm_pkg::*; #(
    parameter int NUM_CH = 8
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // Write address and data
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // Write response
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // Read
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Low power modes
    input wire logic WAIT_MODE,
    input wire logic FREEZE_MODE,
    // Waveform pins
    output logic [7:0] PWM_OUT
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    localparam logic [7:0] CH_MASK = 8'((16'h0001 << NUM_CH) - 16'h0001);
    logic [7:0] en_q, pol_q, sclk_q, prdiv_q, cae_q, ctl_q, ab_q;
    logic [7:0] scl_q [2];
    logic [7:0] per_q [MAX_CH];
    logic [7:0] dty_q [MAX_CH];
    logic [7:0] per_a [MAX_CH];
    logic [7:0] dty_a [MAX_CH];
    logic [7:0] cnt_q [MAX_CH];
    logic [7:0] dir_q, en_act_q, out_q, tick, cnt_clr;
    logic wr_fire, rd_fire, bvalid_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic [7:0] rd_d;
    logic [5:0] widx, ridx;
    logic [2:0] rsub;

    assign widx = S_AXI_AWADDR[7:2];
    assign ridx = S_AXI_ARADDR[7:2];
    assign rsub = 3'(ridx[2:0] - IDX_COUNT0[2:0]);
    assign S_AXI_AWREADY = S_AXI_AWVALID && S_AXI_WVALID && !bvalid_q;
    assign S_AXI_WREADY = S_AXI_AWREADY;
    assign S_AXI_ARREADY = !rvalid_q;
    assign wr_fire = S_AXI_AWREADY;
    assign rd_fire = S_AXI_ARVALID && !rvalid_q;
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RRESP = rresp_q;
    assign S_AXI_RDATA = rdata_q;
    assign PWM_OUT = out_q;

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            en_q <= REG_RESET;
            pol_q <= REG_RESET;
            sclk_q <= REG_RESET;
            prdiv_q <= REG_RESET;
            cae_q <= REG_RESET;
            ctl_q <= REG_RESET;
            ab_q <= REG_RESET;
            scl_q <= '{default: REG_RESET};
            per_q <= '{default: REG_RESET};
            dty_q <= '{default: REG_RESET};
        end else if (wr_fire && S_AXI_WSTRB[0]) begin
            if (widx == IDX_ENABLE) begin
                en_q <= S_AXI_WDATA[7:0] & CH_MASK;
            end else if (widx == IDX_POLARITY) begin
                pol_q <= S_AXI_WDATA[7:0] & CH_MASK;
            end else if (widx == IDX_SCALED_CHOICE) begin
                sclk_q <= S_AXI_WDATA[7:0] & CH_MASK;
            end else if (widx == IDX_PRESCALE) begin
                prdiv_q <= S_AXI_WDATA[7:0] & PRESCALE_WMASK;
            end else if (widx == IDX_CENTRE) begin
                cae_q <= S_AXI_WDATA[7:0] & CH_MASK;
            end else if (widx == IDX_CTRL) begin
                ctl_q <= S_AXI_WDATA[7:0] & CTRL_WMASK;
            end else if (widx == IDX_BASE_PAIR) begin
                ab_q <= S_AXI_WDATA[7:0] & CH_MASK;
            end else if (widx == IDX_SCALE_ONE || widx == IDX_SCALE_TWO) begin
                scl_q[widx[0]] <= S_AXI_WDATA[7:0];
            end else if (widx >= IDX_PERIOD0 && widx < IDX_DUTY0) begin
                per_q[widx[2:0] - IDX_PERIOD0[2:0]] <= S_AXI_WDATA[7:0];
            end else if (widx >= IDX_DUTY0 && widx <= IDX_DUTY0 + 6'h07) begin
                dty_q[widx[2:0] - IDX_DUTY0[2:0]] <= S_AXI_WDATA[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------
    always_comb begin
        rd_d = 8'h00;
        if (ridx == IDX_ENABLE) begin
            rd_d = en_q;
        end else if (ridx == IDX_POLARITY) begin
            rd_d = pol_q;
        end else if (ridx == IDX_SCALED_CHOICE) begin
            rd_d = sclk_q;
        end else if (ridx == IDX_PRESCALE) begin
            rd_d = prdiv_q;
        end else if (ridx == IDX_CENTRE) begin
            rd_d = cae_q;
        end else if (ridx == IDX_CTRL) begin
            rd_d = ctl_q;
        end else if (ridx == IDX_BASE_PAIR) begin
            rd_d = ab_q;
        end else if (ridx == IDX_SCALE_ONE || ridx == IDX_SCALE_TWO) begin
            rd_d = scl_q[ridx[0]];
        end else if (ridx >= IDX_COUNT0 && ridx < IDX_PERIOD0) begin
            rd_d = CH_MASK[rsub] ? cnt_q[rsub] : 8'h00;
        end else if (ridx >= IDX_PERIOD0 && ridx < IDX_DUTY0) begin
            rd_d = CH_MASK[rsub] ? per_q[rsub] : 8'h00;
        end else if (ridx >= IDX_DUTY0 && ridx <= IDX_DUTY0 + 6'h07) begin
            rd_d = CH_MASK[rsub] ? dty_q[rsub] : 8'h00;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h00000000;
        end else begin
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q <= (widx > IDX_LAST) ? RESP_SLVERR : RESP_OKAY;
            end else if (S_AXI_BREADY) begin
                bvalid_q <= 1'b0;
            end
            if (rd_fire) begin
                rvalid_q <= 1'b1;
                rresp_q <= (ridx > IDX_LAST) ? RESP_SLVERR : RESP_OKAY;
                rdata_q <= {24'h000000, rd_d};
            end else if (S_AXI_RREADY) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Prescaler and clock sources
    // ------------------------------------------------------------
    logic pre_run;
    logic [6:0] pre_q, msk_a, msk_b;
    logic [1:0] base_tick, scl_tick;
    logic [7:0] scnt_q [2];
    logic [1:0] shalf_q;

    assign pre_run = |(en_q & CH_MASK)
        && !(WAIT_MODE && ctl_q[WAIT_STOP_BIT])
        && !(FREEZE_MODE && ctl_q[FREEZE_STOP_BIT]);
    assign msk_a = 7'((8'h01 << prdiv_q[FIRST_PRESCALE_LSB +: 3]) - 8'h01);
    assign msk_b = 7'((8'h01 << prdiv_q[SECOND_PRESCALE_LSB +: 3]) - 8'h01);
    assign base_tick[0] = pre_run && ((pre_q & msk_a) == msk_a);
    assign base_tick[1] = pre_run && ((pre_q & msk_b) == msk_b);

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            pre_q <= 7'h00;
        end else if (pre_run) begin
            pre_q <= pre_q + 7'h01;
        end
    end

    for (genvar k = 0; k < 2; k++) begin : g_scale
        logic last;
        assign last = (scnt_q[k] == 8'(scl_q[k] - 8'h01));
        assign scl_tick[k] = base_tick[k] && last && shalf_q[k];
        always_ff @(posedge CORE_CLK or posedge RST) begin
            if (RST) begin
                scnt_q[k] <= 8'h00;
                shalf_q[k] <= 1'b0;
            end else if (base_tick[k]) begin
                scnt_q[k] <= last ? 8'h00 : scnt_q[k] + 8'h01;
                if (last) begin
                    shalf_q[k] <= !shalf_q[k];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Counter step: returns {reload, down, count}
    // ------------------------------------------------------------
    function automatic logic [17:0] pwm_step(input logic [15:0] c, input logic [15:0] pr,
                                             input logic dn, input logic ctr);
        logic [16:0] nx;
        nx = {1'b0, c} + 17'h00001;
        pwm_step = {1'b0, dn, 16'(nx)};
        if (!ctr) begin
            if (nx >= {1'b0, pr}) begin
                pwm_step = {1'b1, 1'b0, 16'h0000};
            end
        end else if (!dn) begin
            if (nx > {1'b0, pr}) begin
                pwm_step = (c == 16'h0000) ? {1'b1, 1'b0, 16'h0000} : {1'b0, 1'b1, 16'(c - 16'h0001)};
            end
        end else if (c <= 16'h0001) begin
            pwm_step = {1'b1, 1'b0, 16'h0000};
        end else begin
            pwm_step = {1'b0, 1'b1, 16'(c - 16'h0001)};
        end
    endfunction : pwm_step

    // Duty test; in centre mode the peak and down samples include the duty value
    function automatic logic duty_on(input logic [15:0] c, input logic [15:0] d,
                                     input logic [15:0] pr, input logic dn, input logic ctr);
        duty_on = (c < d) || (ctr && (dn || c == pr) && c == d);
    endfunction : duty_on

    // ------------------------------------------------------------
    // Channel pairs
    // ------------------------------------------------------------
    for (genvar i = 0; i < MAX_CH; i++) begin : g_src
        logic base_sel;
        assign base_sel = ab_q[i] ^ i[1];
        assign tick[i] = sclk_q[i] ? scl_tick[base_sel] : base_tick[base_sel];
        assign cnt_clr[i] = wr_fire && S_AXI_WSTRB[0] && (widx == IDX_COUNT0 + 6'(i));
    end

    for (genvar p = 0; p < MAX_CH / 2; p++) begin : g_pair
        localparam int E = 2 * p;
        localparam int O = 2 * p + 1;
        logic cat;
        logic [1:0] en_eff;
        logic [17:0] r16;
        logic [17:0] r8 [2];
        logic [15:0] c16, d16, p16;
        logic [7:0] pcnt_q [2];
        logic [7:0] pper_q [2];
        logic [7:0] pdty_q [2];
        logic [1:0] pdir_q, pact_q, pout_q, hit8;
        logic hit16;
        assign cat = ctl_q[JOIN_LSB + p];
        assign c16 = {pcnt_q[0], pcnt_q[1]};
        assign d16 = {pdty_q[0], pdty_q[1]};
        assign p16 = {pper_q[0], pper_q[1]};
        assign r16 = pwm_step(c16, p16, pdir_q[1], cae_q[O]);
        assign r8[0] = pwm_step({8'h00, pcnt_q[0]}, {8'h00, pper_q[0]}, pdir_q[0], cae_q[E]);
        assign r8[1] = pwm_step({8'h00, pcnt_q[1]}, {8'h00, pper_q[1]}, pdir_q[1], cae_q[O]);
        assign hit16 = duty_on(c16, d16, p16, pdir_q[1], cae_q[O]);
        assign hit8[0] = duty_on({8'h00, pcnt_q[0]}, {8'h00, pdty_q[0]}, {8'h00, pper_q[0]},
            pdir_q[0], cae_q[E]);
        assign hit8[1] = duty_on({8'h00, pcnt_q[1]}, {8'h00, pdty_q[1]}, {8'h00, pper_q[1]},
            pdir_q[1], cae_q[O]);
        assign en_eff[0] = en_q[E] && !cat;
        assign en_eff[1] = en_q[O];
        for (genvar h = 0; h < 2; h++) begin : g_pub
            assign cnt_q[E + h] = pcnt_q[h];
            assign per_a[E + h] = pper_q[h];
            assign dty_a[E + h] = pdty_q[h];
            assign dir_q[E + h] = pdir_q[h];
            assign en_act_q[E + h] = pact_q[h];
            assign out_q[E + h] = pout_q[h];
        end

        always_ff @(posedge CORE_CLK or posedge RST) begin
            if (RST) begin
                pcnt_q <= '{default: 8'h00};
                pper_q <= '{default: 8'h00};
                pdty_q <= '{default: 8'h00};
                pdir_q <= 2'b00;
                pact_q <= 2'b00;
                pout_q <= 2'b00;
            end else begin
                for (int j = 0; j < 2; j++) begin
                    if (!en_eff[j]) begin
                        pact_q[j] <= 1'b0;
                    end else if (tick[E + j]) begin
                        pact_q[j] <= 1'b1;
                    end
                end
                if (cat) begin
                    if (!pact_q[1] || cnt_clr[E] || cnt_clr[O]) begin
                        {pcnt_q[0], pcnt_q[1]} <= 16'h0000;
                        pdir_q[1] <= 1'b0;
                        {pper_q[0], pper_q[1]} <= {per_q[E], per_q[O]};
                        {pdty_q[0], pdty_q[1]} <= {dty_q[E], dty_q[O]};
                    end else if (tick[O]) begin
                        {pcnt_q[0], pcnt_q[1]} <= r16[15:0];
                        pdir_q[1] <= r16[16];
                        if (r16[17]) begin
                            {pper_q[0], pper_q[1]} <= {per_q[E], per_q[O]};
                            {pdty_q[0], pdty_q[1]} <= {dty_q[E], dty_q[O]};
                        end
                    end
                    pout_q[0] <= 1'b0;
                    pout_q[1] <= pact_q[1] && (hit16 ? pol_q[O] : !pol_q[O]);
                end else begin
                    for (int j = 0; j < 2; j++) begin
                        if (!pact_q[j] || cnt_clr[E + j]) begin
                            pcnt_q[j] <= 8'h00;
                            pdir_q[j] <= 1'b0;
                            pper_q[j] <= per_q[E + j];
                            pdty_q[j] <= dty_q[E + j];
                        end else if (tick[E + j]) begin
                            pcnt_q[j] <= r8[j][7:0];
                            pdir_q[j] <= r8[j][16];
                            if (r8[j][17]) begin
                                pper_q[j] <= per_q[E + j];
                                pdty_q[j] <= dty_q[E + j];
                            end
                        end
                        pout_q[j] <= pact_q[j]
                            && (hit8[j] ? pol_q[E + j] : !pol_q[E + j]);
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    a_write_answer: assert property (wr_fire |=> S_AXI_BVALID)
        else $error("write not answered");
    a_reserved_zero: assert property (rd_fire && ridx == 6'h07 |=> S_AXI_RDATA == 32'h0)
        else $error("reserved register not zero");
    a_prescale_idle: assert property (!(|(en_q & CH_MASK)) |=> $stable(pre_q))
        else $error("prescaler ran with channels off");
    a_wait_gate: assert property (WAIT_MODE && ctl_q[WAIT_STOP_BIT] |=> $stable(pre_q))
        else $error("prescaler ran in wait");
    a_freeze_gate: assert property (FREEZE_MODE && ctl_q[FREEZE_STOP_BIT] |=> $stable(pre_q))
        else $error("prescaler ran in freeze");
    a_enable_store: assert property (wr_fire && S_AXI_WSTRB[0] && widx == IDX_ENABLE
        |=> en_q == ($past(S_AXI_WDATA[7:0]) & CH_MASK))
        else $error("enable not stored");
    a_join_low_off: assert property (ctl_q[JOIN_LSB] |=> !PWM_OUT[0])
        else $error("joined upper output active");
    a_absent_off: assert property ((PWM_OUT & ~CH_MASK) == 8'h00)
        else $error("absent channel drives");
    a_off_output: assert property (!en_q[1] ##1 !en_q[1] |=> !PWM_OUT[1])
        else $error("disabled channel output active");

    c_centre_run: cover property (cae_q[0] && dir_q[0] && en_act_q[0]);
    c_joined_run: cover property (ctl_q[JOIN_LSB] && en_act_q[1] && PWM_OUT[1]);
    c_bus_error: cover property (S_AXI_BVALID && S_AXI_BRESP == RESP_SLVERR);
endmodule : spwm_top

// [sim/spwm_load.sv]
// External load model that counts high time and transitions on each pin
`timescale 1ns/10ps
module spwm_load (
    // Clock and window clear
    input wire logic clk,
    input wire logic clr,
    // Waveform pins
    input wire logic [7:0] pins
);
    int unsigned highs [8];
    int unsigned edges [8];
    logic [7:0] last_q;
    // ------------------------------------------------------------
    // Counting window
    // ------------------------------------------------------------
    always @(posedge clk) begin
        last_q <= pins;
        for (int i = 0; i < 8; i++) begin
            highs[i] <= clr ? 0 : highs[i] + pins[i];
            edges[i] <= clr ? 0 : edges[i] + (pins[i] != last_q[i]);
        end
    end
endmodule : spwm_load

// [sim/spwm_top_test.sv]
// Self-checking bench for the scalable pulse-width channels
`timescale 1ns/10ps
module spwm_top_test import spwm_pkg::*;;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr, araddr, d, pol_v, cae_v, scl_v, ab_v;
    logic awvalid, wvalid, bready, arvalid, rready, wait_m, frz_m, clr;
    logic [31:0] wdata, rv;
    logic [3:0] wstrb;
    logic [1:0] rr;
    wire logic awready, wready, bvalid, arready, rvalid;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [7:0] pwm, pwm_two;
    int n_errors = 0;
    int n_compared = 0;
    int seed = 37;
    int per [8];
    int dty [8];
    int pre_a, pre_b, sa, sb, got, exp_v;
    always #4 clk = ~clk;
    // ------------------------------------------------------------
    // Design instances and load
    // ------------------------------------------------------------
    spwm_top #(.NUM_CH(8)) i_dut (.CORE_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .WAIT_MODE(wait_m), .FREEZE_MODE(frz_m), .PWM_OUT(pwm));
    spwm_top #(.NUM_CH(2)) i_dut_two (.CORE_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(),
        .S_AXI_BRESP(), .S_AXI_BVALID(), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(),
        .S_AXI_RDATA(), .S_AXI_RRESP(), .S_AXI_RVALID(),
        .S_AXI_RREADY(rready), .WAIT_MODE(wait_m), .FREEZE_MODE(frz_m), .PWM_OUT(pwm_two));
    spwm_load i_load (.clk(clk), .clr(clr), .pins(pwm));
    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic close_out;
        if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL at %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk
    task automatic hang(input int k);
        if (k >= 200) begin
            n_errors++;
            close_out();
        end
    endtask : hang
    task automatic wr(input int idx, input logic [7:0] v, input logic [3:0] st,
                      output logic [1:0] r);
        int k;
        k = 0;
        awaddr <= 8'(idx * 4);
        wdata <= {24'h000000, v};
        wstrb <= st;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (!(awready === 1'b1 && wready === 1'b1) && k < 200);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do begin
            @(posedge clk);
            k++;
        end while (bvalid !== 1'b1 && k < 200);
        r = bresp;
        hang(k);
    endtask : wr
    task automatic rd(input int idx, output logic [31:0] v, output logic [1:0] r);
        int k;
        k = 0;
        araddr <= 8'(idx * 4);
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (arready !== 1'b1 && k < 200);
        arvalid <= 1'b0;
        do begin
            @(posedge clk);
            k++;
        end while (rvalid !== 1'b1 && k < 200);
        v = rdata;
        r = rresp;
        hang(k);
    endtask : rd
    task automatic w(input int idx, input logic [7:0] v);
        logic [1:0] r;
        wr(idx, v, 4'hF, r);
        chk(r, RESP_OKAY);
    endtask : w
    task automatic measure(input int n);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (n) @(posedge clk);
        #1;
    endtask : measure
    // ------------------------------------------------------------
    // Reference model
    // ------------------------------------------------------------
    function automatic logic [7:0] wmask(input int i);
        if (i == 3) return PRESCALE_WMASK;
        if (i == 5) return CTRL_WMASK;
        if (i == 7 || i == 10 || i == 11 || i > 35) return 8'h00;
        return 8'hFF;
    endfunction : wmask
    function automatic int expect_hi(input int i, input int wl);
        int use_a, dv, m;
        use_a = int'((i % 4) < 2) ^ int'(ab_v[i]);
        dv = 1 << (use_a ? pre_a : pre_b);
        if (scl_v[i]) dv = dv * 2 * (use_a ? sa : sb);
        m = cae_v[i] ? 2 : 1;
        return (wl / (per[i] * m * dv)) * (pol_v[i] ? dty[i] : per[i] - dty[i]) * m * dv;
    endfunction : expect_hi
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {awaddr, araddr, wdata, awvalid, wvalid, arvalid, wait_m, frz_m, clr} = '0;
        wstrb = 4'hF;
        bready = 1'b1;
        rready = 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i <= 40; i++) begin
            rd(i, rv, rr);
            chk(rv, 32'h0);
            chk(rr, (i > 39) ? RESP_SLVERR : RESP_OKAY);
        end
        wr(40, 8'hFF, 4'hF, rr);
        chk(rr, RESP_SLVERR);
        for (int i = 1; i < 40; i++) begin
            if (i >= 12 && i < 20) continue;
            d = 8'($random(seed));
            w(i, d);
            rd(i, rv, rr);
            chk(rv, {24'h0, d & wmask(i)});
            wr(i, ~d, 4'hE, rr);
            rd(i, rv, rr);
            chk(rv, {24'h0, d & wmask(i)});
        end
        for (int r = 0; r < 2; r++) begin
            if (r == 0) begin
                {pol_v, cae_v, scl_v, ab_v} = {$random(seed)};
                pre_a = $unsigned($random(seed)) % 2;
                pre_b = $unsigned($random(seed)) % 2;
                sa = 1 + $unsigned($random(seed)) % 2;
                sb = 1 + $unsigned($random(seed)) % 2;
                w(IDX_POLARITY, pol_v);
                w(IDX_CENTRE, cae_v);
                w(IDX_SCALED_CHOICE, scl_v);
                w(IDX_BASE_PAIR, ab_v);
                w(IDX_PRESCALE, 8'(pre_b * 16 + pre_a));
                w(IDX_SCALE_ONE, 8'(sa));
                w(IDX_SCALE_TWO, 8'(sb));
                w(IDX_CTRL, 8'h00);
            end
            for (int i = 0; i < 8; i++) begin
                per[i] = 4 << ($unsigned($random(seed)) % 3);
                dty[i] = $unsigned($random(seed)) % (per[i] + 1);
                w(IDX_PERIOD0 + i, 8'(per[i]));
                w(IDX_DUTY0 + i, 8'(dty[i]));
            end
            if (r == 0) begin
                chk(pwm, 8'h00);
                w(IDX_ENABLE, 8'hFF);
                rd(IDX_ENABLE, rv, rr);
                chk(rv, 32'hFF);
            end
            repeat (700) @(posedge clk);
            measure(512);
            chk(pwm_two, {6'h00, pwm[1:0]});
            for (int i = 0; i < 8; i++) begin
                chk(i_load.highs[i], expect_hi(i, 512));
            end
        end
        w(IDX_ENABLE, 8'h00);
        w(IDX_CENTRE, 8'h00);
        w(IDX_SCALED_CHOICE, 8'h00);
        w(IDX_BASE_PAIR, 8'h00);
        w(IDX_PRESCALE, 8'h00);
        w(IDX_POLARITY, 8'h06);
        w(IDX_CTRL, 8'h10);
        w(IDX_PERIOD0, 8'h00);
        w(IDX_PERIOD0 + 1, 8'h10);
        w(IDX_DUTY0, 8'h00);
        w(IDX_DUTY0 + 1, 8'h04);
        w(IDX_PERIOD0 + 2, 8'h08);
        w(IDX_DUTY0 + 2, 8'h04);
        w(IDX_ENABLE, 8'h02);
        repeat (100) @(posedge clk);
        measure(512);
        chk(i_load.highs[1], 128);
        chk(i_load.highs[0], 0);
        w(IDX_ENABLE, 8'h01);
        repeat (40) @(posedge clk);
        measure(64);
        chk(i_load.highs[1] + i_load.highs[0], 0);
        w(IDX_ENABLE, 8'h04);
        for (int m = 0; m < 2; m++) begin
            for (int g = 0; g < 2; g++) begin
                w(IDX_CTRL, g ? (m ? 8'h04 : 8'h08) : 8'h00);
                wait_m <= (m == 0);
                frz_m <= (m == 1);
                if (g) begin
                    w(IDX_COUNT0 + 2, 8'h5A);
                    rd(IDX_COUNT0 + 2, rv, rr);
                    chk(rv, 32'h0);
                end
                repeat (40) @(posedge clk);
                measure(64);
                got = g ? i_load.edges[2] : i_load.highs[2];
                exp_v = g ? 0 : 32;
                if (m == 0) chk(got, exp_v);
                else chk(got, exp_v);
            end
        end
        close_out();
    end
    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        close_out();
    end
endmodule : spwm_top_test
